// File: hdl/sra_pkg.sv
// shared constants of the serial register port, both ends
package sra_pkg;
	localparam int unsigned FRAME_BITS   = 8;
	localparam int unsigned CNT_W        = 3;      // modulo-8 clock counter
	localparam int unsigned CLK_NS       = 8;      // core clock period
	localparam int unsigned SCK_HALF_NS  = 64;     // host serial clock half
	localparam int unsigned SCK_HALF_CYC = (SCK_HALF_NS / CLK_NS < 1) ? 1 :
		SCK_HALF_NS / CLK_NS;
	// command fields
	localparam int unsigned WR_BIT   = 7;
	localparam int unsigned ADDR_MSB = 6;
	localparam int unsigned ADDR_LSB = 4;
	localparam int unsigned STD_BIT  = 1;
	localparam int unsigned BANK_BIT = 0;
	localparam int unsigned CLAMP_BIT = 0;
	localparam logic [2:0] CMD_ADDR    = 3'h6;
	localparam logic [2:0] UNUSED_ADDR = 3'h7;
	// reset values
	localparam logic       ERR_FLAG_RST = 1'h1;
	localparam logic [3:0] CTRL_RST = 4'h0;
	// answer headers
	localparam logic [1:0] STD_HDR  = 2'h0;
	localparam logic [1:0] DIAGNOSIS_HDR = 2'h1;
	localparam logic       CTRL_HDR = 1'h1;
	typedef logic [FRAME_BITS-1:0] sra_byte_t;
endpackage : sra_pkg

// File: hdl/sra_if.sv
// serial link between host and device, one modport per end
`timescale 1ns/1ps
`default_nettype none
interface sra_if;
	logic cs_n;      // chain_select, active low
	logic sclk;      // serial clock from host
	logic host_out;  // host to device serial input
	logic dev_so;    // device serial output value
	logic dev_so_oe; // device drives serial output
	logic host_in;   // resolved line seen by host
	// undriven line reads low here, a stand-in for a weak pull
	assign host_in = dev_so_oe & dev_so;
	modport dev  (input cs_n, input sclk, input host_out,
		output dev_so, output dev_so_oe);
	modport host (output cs_n, output sclk, output host_out,
		input host_in);
endinterface : sra_if
`default_nettype wire

// File: hdl/sra_sync.sv
// two-flop synchroniser with edge pulses for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sra_sync #(
	parameter int unsigned W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         core_clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);
	logic [W-1:0] meta_r, sync_r, old_r;

	// first stage is read only by the second
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
			old_r  <= RST_VAL;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
			old_r  <= sync_r;
		end
	end

	// edges from the settled stages only
	assign q_o    = sync_r;
	assign rise_o = sync_r & ~old_r;
	assign fall_o = ~sync_r & old_r;
endmodule : sra_sync
`default_nettype wire

// File: hdl/sra_dev.sv
// device end: serial slave with control and diagnosis register banks
// Summary of operation
// - chip select fall starts, rise ends transfer
// - sample input on fall, output on rise
// - modulo-8 clock count gates data acceptance
// - ignore pins, output released while deselected
// - load diagnosis word at select fall
// - error OR input shown until first rise
// - decode only nonzero multiple of eight
// - copy shift register to input matrix
// - host keeps clock low at select edges
// - eight-bit frames, most significant bit first
// - chained devices pass bits, 8 per device
// - eight control, four diagnosis 4-bit registers
// - write: bit7 set, address, value stored
// - read: bank bit, or standard diagnosis request
// - standard word: awake, limp home, pair faults
// - read answered in second frame, low nibble
// - second frame command executes normally
// - error flag: cleared ok, set fail/reset
// - reset restores all protocol state
// - command bits self-clear, clamp after frame
`timescale 1ns/1ps
`default_nettype none
module sra_dev (
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_i,
	sra_if.dev                          link,
	input  wire logic                   awake_flag_i,
	input  wire logic                   limp_home_flag_i,
	input  wire logic [3:0]             pair_fault_alert_i,
	input  wire logic [15:0]            diagnosis_bank_i,
	output logic      [31:0]            control_bank_o,
	output logic      [3:0]             cmd_exec_o,
	output logic                        clamp_command_bit_o,
	output logic                        transmission_error_flag_o,
	output sra_pkg::sra_byte_t          input_matrix_o,
	output logic                        frame_done_o
);
	import sra_pkg::*;

	logic [2:0] pin_q, pin_rise, pin_fall;
	logic       cs_rise, cs_fall, sclk_rise, sclk_fall, si_q;

	// cs idles high; first flop never leaves the synchroniser
	sra_sync #(
		.W       (3),
		.RST_VAL (3'h4)
	) u_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.d_i        ({link.cs_n, link.sclk, link.host_out}),
		.q_o        (pin_q),
		.rise_o     (pin_rise),
		.fall_o     (pin_fall)
	);

	assign cs_rise   = pin_rise[2];
	assign cs_fall   = pin_fall[2];
	assign sclk_rise = pin_rise[1];
	assign sclk_fall = pin_fall[1];
	assign si_q      = pin_q[0];

	sra_byte_t        shreg_r, shreg_nxt;
	sra_byte_t        in_mat_r, in_mat_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic             seen_r, seen_nxt;
	logic             active_r, active_nxt;
	logic             pre_r, pre_nxt;
	logic             so_r, so_nxt;
	logic             err_r, err_nxt;
	logic             rd_pend_r, rd_pend_nxt;
	logic             rd_bank_r, rd_bank_nxt;
	logic [2:0]       rd_addr_r, rd_addr_nxt;
	logic [3:0]       exec_r, exec_nxt;
	logic             done_r, done_nxt;
	logic [3:0]       ctrl_r [8];
	logic [3:0]       ctrl_nxt [8];

	// word placed in the shift register at select fall
	function automatic sra_byte_t load_word(
		input logic       pend,
		input logic       bank,
		input logic [2:0] addr,
		input logic [3:0] cval,
		input logic [15:0] dbank,
		input logic       awake,
		input logic       limp,
		input logic [3:0] pf
	);
		sra_byte_t w;
		w = {STD_HDR, awake, limp, pf};
		if (pend) begin
			if (bank)
				w = {DIAGNOSIS_HDR, addr[1:0],
					dbank[addr[1:0]*4 +: 4]};
			else
				w = {CTRL_HDR, addr, cval};
		end
		return w;
	endfunction : load_word

	// protocol sequencing and command decode
	always_comb begin
		logic [2:0] a;
		a           = shreg_r[ADDR_MSB:ADDR_LSB];
		shreg_nxt   = shreg_r;
		in_mat_nxt  = in_mat_r;
		cnt_nxt     = cnt_r;
		seen_nxt    = seen_r;
		active_nxt  = active_r;
		pre_nxt     = pre_r;
		so_nxt      = so_r;
		err_nxt     = err_r;
		rd_pend_nxt = rd_pend_r;
		rd_bank_nxt = rd_bank_r;
		rd_addr_nxt = rd_addr_r;
		exec_nxt    = '0;                          // pulses only
		done_nxt    = 1'b0;
		for (int i = 0; i < 8; i++)
			ctrl_nxt[i] = ctrl_r[i];
		if (cs_fall) begin                         // start of access
			active_nxt = 1'b1;
			pre_nxt    = 1'b1;
			cnt_nxt    = '0;
			seen_nxt   = 1'b0;
			shreg_nxt  = load_word(rd_pend_r, rd_bank_r, rd_addr_r,
				ctrl_r[rd_addr_r], diagnosis_bank_i, awake_flag_i,
				limp_home_flag_i, pair_fault_alert_i);
			so_nxt     = err_r | si_q;
		end else if (active_r && cs_rise) begin    // end of access
			active_nxt = 1'b0;
			done_nxt   = 1'b1;
			in_mat_nxt = shreg_r;
			if (seen_r && cnt_r == '0) begin
				err_nxt = 1'b0;
				// clamp bit lives until the next good frame
				ctrl_nxt[CMD_ADDR][CLAMP_BIT] = 1'b0;
				if (shreg_r[WR_BIT]) begin
					rd_pend_nxt = 1'b0;
					if (a == CMD_ADDR) begin
						exec_nxt = shreg_r[3:0];
						ctrl_nxt[CMD_ADDR][CLAMP_BIT] = shreg_r[CLAMP_BIT];
					end else if (a != UNUSED_ADDR) begin
						ctrl_nxt[a] = shreg_r[3:0];
					end
				end else if (shreg_r[STD_BIT]) begin
					rd_pend_nxt = 1'b0;
				end else begin
					rd_pend_nxt = 1'b1;
					rd_bank_nxt = shreg_r[BANK_BIT];
					rd_addr_nxt = a;
				end
			end else begin
				err_nxt = 1'b1;                        // discard
			end
		end else if (active_r) begin
			if (pre_r)
				so_nxt = err_r | si_q;                 // chain sees error
			if (sclk_rise) begin
				pre_nxt = 1'b0;
				so_nxt  = shreg_r[FRAME_BITS-1];       // msb first
			end
			if (sclk_fall) begin
				// bits beyond eight pass on down the chain
				shreg_nxt = {shreg_r[FRAME_BITS-2:0], si_q};
				cnt_nxt   = cnt_r + 1'b1;              // wraps at 8
				seen_nxt  = 1'b1;
			end
		end
	end

	// registers of the protocol and the control bank
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			shreg_r   <= '0;
			in_mat_r  <= '0;
			cnt_r     <= '0;
			seen_r    <= 1'b0;
			active_r  <= 1'b0;
			pre_r     <= 1'b0;
			so_r      <= 1'b0;
			err_r     <= ERR_FLAG_RST;
			rd_pend_r <= 1'b0;
			rd_bank_r <= 1'b0;
			rd_addr_r <= '0;
			exec_r    <= '0;
			done_r    <= 1'b0;
			for (int i = 0; i < 8; i++)
				ctrl_r[i] <= CTRL_RST;
		end else begin
			shreg_r   <= shreg_nxt;
			in_mat_r  <= in_mat_nxt;
			cnt_r     <= cnt_nxt;
			seen_r    <= seen_nxt;
			active_r  <= active_nxt;
			pre_r     <= pre_nxt;
			so_r      <= so_nxt;
			err_r     <= err_nxt;
			rd_pend_r <= rd_pend_nxt;
			rd_bank_r <= rd_bank_nxt;
			rd_addr_r <= rd_addr_nxt;
			exec_r    <= exec_nxt;
			done_r    <= done_nxt;
			for (int i = 0; i < 8; i++)
				ctrl_r[i] <= ctrl_nxt[i];
		end
	end

	// output released whenever the device is not selected
	assign link.dev_so    = so_r;
	assign link.dev_so_oe = active_r;

	always_comb begin
		for (int i = 0; i < 8; i++)
			control_bank_o[i*4 +: 4] = ctrl_r[i];
	end

	assign cmd_exec_o                = exec_r;
	assign clamp_command_bit_o       = ctrl_r[CMD_ADDR][CLAMP_BIT];
	assign transmission_error_flag_o = err_r;
	assign input_matrix_o            = in_mat_r;
	assign frame_done_o              = done_r;
endmodule : sra_dev
`default_nettype wire

// File: hdl/sra_host.sv
// host end: serial master that clocks one frame group per request
`timescale 1ns/1ps
`default_nettype none
module sra_host #(
	parameter int unsigned HALF = sra_pkg::SCK_HALF_CYC
) (
	input  wire logic               core_clk_i,
	input  wire logic               rst_i,
	sra_if.host                     link,
	input  wire logic               req_valid_i,
	input  wire sra_pkg::sra_byte_t req_byte_i,
	input  wire logic [4:0]         req_nclk_i,
	output logic                    req_ready_o,
	output logic                    rsp_valid_o,
	output sra_pkg::sra_byte_t      rsp_byte_o,
	output logic                    rsp_flag_o
);
	import sra_pkg::*;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_LEAD = 3'h1,
		H_LOW  = 3'h2,
		H_HIGH = 3'h3,
		H_TAIL = 3'h4
	} sra_hst_t;

	sra_hst_t   st_r, st_nxt;
	logic [7:0] tmr_r, tmr_nxt;
	logic [4:0] left_r, left_nxt;
	logic       first_r, first_nxt;
	sra_byte_t  tx_r, tx_nxt, rx_r, rx_nxt;
	logic       cs_n_r, cs_n_nxt, sclk_r, sclk_nxt, hout_r, hout_nxt;
	logic       vld_r, vld_nxt, flag_r, flag_nxt;
	logic       hin_q;

	// the device answer is a pin to this end
	sra_sync #(
		.W       (1),
		.RST_VAL (1'h0)
	) u_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.d_i        (link.host_in),
		.q_o        (hin_q),
		.rise_o     (),
		.fall_o     ()
	);

	// clock divider and bit sequencer; sclk low at select edges
	always_comb begin
		st_nxt    = st_r;
		tmr_nxt   = tmr_r;
		left_nxt  = left_r;
		first_nxt = first_r;
		tx_nxt    = tx_r;
		rx_nxt    = rx_r;
		cs_n_nxt  = cs_n_r;
		sclk_nxt  = sclk_r;
		hout_nxt  = hout_r;
		vld_nxt   = 1'b0;
		flag_nxt  = flag_r;
		if (tmr_r != '0)
			tmr_nxt = tmr_r - 1'b1;
		unique case (st_r)
			H_IDLE: begin
				if (req_valid_i) begin
					cs_n_nxt  = 1'b0;
					tx_nxt    = req_byte_i;
					hout_nxt  = req_byte_i[FRAME_BITS-1]; // msb first
					left_nxt  = req_nclk_i;
					first_nxt = 1'b1;
					tmr_nxt   = 8'(HALF);
					st_nxt    = H_LEAD;
				end
			end
			H_LEAD: begin
				if (tmr_r == '0) begin
					// first bit must stand to the first fall, so the
					// first high phase keeps it; cleared at its end
					flag_nxt = hin_q;                // chain error level
					st_nxt   = (left_r == '0) ? H_TAIL : H_HIGH;
					sclk_nxt = (left_r != '0);
					tmr_nxt  = 8'(HALF);
				end
			end
			H_HIGH: begin
				// new data mid-high, safe from the device sample
				if (tmr_r == 8'(HALF / 2) && !first_r) begin
					tx_nxt = {tx_r[FRAME_BITS-2:0], 1'b0};
					hout_nxt = tx_r[FRAME_BITS-2];
				end
				if (tmr_r == '0) begin
					rx_nxt    = {rx_r[FRAME_BITS-2:0], hin_q};
					first_nxt = 1'b0;
					sclk_nxt  = 1'b0;
					left_nxt  = left_r - 1'b1;
					tmr_nxt   = 8'(HALF);
					st_nxt    = (left_r == 5'h1) ? H_TAIL : H_LOW;
				end
			end
			H_LOW: begin
				if (tmr_r == '0) begin
					sclk_nxt = 1'b1;
					tmr_nxt  = 8'(HALF);
					st_nxt   = H_HIGH;
				end
			end
			H_TAIL: begin
				if (tmr_r == '0 && !cs_n_r) begin
					cs_n_nxt = 1'b1;
					vld_nxt  = 1'b1;
					tmr_nxt  = 8'(HALF);
				end else if (tmr_r == '0) begin
					st_nxt = H_IDLE;
				end
			end
			default: st_nxt = H_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_r    <= H_IDLE;
			tmr_r   <= '0;
			left_r  <= '0;
			first_r <= 1'b0;
			tx_r    <= '0;
			rx_r    <= '0;
			cs_n_r  <= 1'b1;
			sclk_r  <= 1'b0;
			hout_r  <= 1'b0;
			vld_r   <= 1'b0;
			flag_r  <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			tmr_r   <= tmr_nxt;
			left_r  <= left_nxt;
			first_r <= first_nxt;
			tx_r    <= tx_nxt;
			rx_r    <= rx_nxt;
			cs_n_r  <= cs_n_nxt;
			sclk_r  <= sclk_nxt;
			hout_r  <= hout_nxt;
			vld_r   <= vld_nxt;
			flag_r  <= flag_nxt;
		end
	end

	assign link.cs_n     = cs_n_r;
	assign link.sclk     = sclk_r;
	assign link.host_out = hout_r;
	assign req_ready_o   = (st_r == H_IDLE);
	assign rsp_valid_o   = vld_r;
	assign rsp_byte_o    = rx_r;
	assign rsp_flag_o    = flag_r;
endmodule : sra_host
`default_nettype wire

// File: test/sra_link_assertions.sv
// concurrent checks on the serial link between the two ends
`timescale 1ns/1ps
`default_nettype none
module sra_link_assertions (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic host_out,
	input wire logic dev_so,
	input wire logic dev_so_oe,
	input wire logic host_in
);
	import sra_pkg::*;
	// single domain, so one clocking and one reset guard for all
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	AST_OE_ON: assert property ($fell(cs_n) |-> ##[1:5] dev_so_oe)
		else $error("output not driven after select");
	AST_OE_HELD: assert property (!cs_n [*6] |-> dev_so_oe)
		else $error("output dropped inside frame");
	AST_OE_OFF: assert property ($rose(cs_n) |-> ##[1:5] !dev_so_oe)
		else $error("output not released after select");
	AST_OE_IDLE: assert property (cs_n [*6] |-> !dev_so_oe)
		else $error("output driven while deselected");
	AST_SCLK_QUIET: assert property (
		$changed(cs_n) |-> !sclk && !$past(sclk))
		else $error("serial clock high at select edge");
	AST_SCLK_PHASE: assert property ($rose(sclk) |-> sclk [*6])
		else $error("serial clock high phase too short");
	// first bit is error flag or input, so a high input forces high
	AST_FIRST_OR: assert property (
		$fell(cs_n) ##5 1'b1 |-> dev_so || !host_out)
		else $error("first bit lacks input level");
	AST_FIRST_HOLD: assert property (
		$fell(cs_n) ##6 1'b1 |-> $stable(dev_so) [*3])
		else $error("first bit not held to clock rise");
	// output may only move after a rise, never in the low phase
	AST_SO_LOW_STEADY: assert property (
		$fell(sclk) |-> $stable(dev_so) [*6])
		else $error("output moved while clock low");
	CV_FRAME: cover property ($fell(cs_n) ##[1:300] $rose(cs_n));
	CV_HIGH_BIT: cover property (sclk && host_in);
	CV_RELEASE: cover property ($rose(cs_n) ##[1:5] !dev_so_oe);
endmodule : sra_link_assertions
`default_nettype wire

// File: test/spi_slave_register_access_tb.sv
// self-checking bench: host end and device end on one link
`timescale 1ns/1ps
`default_nettype none
module spi_slave_register_access_tb;
	import sra_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        req_valid = 1'b0;
	sra_byte_t   req_byte = 8'h00;
	logic [4:0]  req_nclk = 5'h00;
	logic        awake_in = 1'b0;
	logic        limp_in = 1'b0;
	logic [3:0]  pf = 4'h0;
	logic [15:0] dbank = 16'h0000;
	logic        req_ready, rsp_valid, rsp_flag, clamp, err_flag, sclk_q;
	logic        frame_done;
	sra_byte_t   rsp_byte, in_matrix, wire_byte;
	logic [3:0]  exec, last_exec;
	logic [31:0] ctrl_bank;
	logic [31:0] seed = 32'h4be4;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          done_cnt = 0;
	int          bad[5] = '{0, 1, 7, 9, 15};
	// reference model: kind 0 standard, 1 diagnosis, 2 control
	logic [3:0]  m_ctrl[8];
	logic        m_err;
	int          m_kind;
	logic [2:0]  m_addr;

	sra_if link();
	sra_dev sra_dev_i (.core_clk_i(core_clk), .rst_i(rst), .link(link),
		.awake_flag_i(awake_in), .limp_home_flag_i(limp_in),
		.pair_fault_alert_i(pf),
		.diagnosis_bank_i(dbank), .control_bank_o(ctrl_bank),
		.cmd_exec_o(exec), .clamp_command_bit_o(clamp),
		.transmission_error_flag_o(err_flag), .input_matrix_o(in_matrix),
		.frame_done_o(frame_done));
	sra_host #(.HALF(8)) sra_host_i (.core_clk_i(core_clk), .rst_i(rst),
		.link(link), .req_valid_i(req_valid), .req_byte_i(req_byte),
		.req_nclk_i(req_nclk), .req_ready_o(req_ready),
		.rsp_valid_o(rsp_valid), .rsp_byte_o(rsp_byte),
		.rsp_flag_o(rsp_flag));
	sra_link_assertions chk_i (.core_clk_i(core_clk), .rst_i(rst),
		.cs_n(link.cs_n), .sclk(link.sclk), .host_out(link.host_out),
		.dev_so(link.dev_so), .dev_so_oe(link.dev_so_oe),
		.host_in(link.host_in));

	always #4 core_clk = ~core_clk;

	// catch command pulses, and host bits at each clock fall
	always @(posedge core_clk) begin
		if (exec !== 4'h0)
			last_exec <= exec;
		if (frame_done === 1'b1)
			done_cnt <= done_cnt + 1;
		sclk_q <= link.sclk;
		if (sclk_q && !link.sclk)
			wire_byte <= {wire_byte[6:0], link.host_out};
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// word the device must load at select fall
	function automatic sra_byte_t answer();
		case (m_kind)
			1: return {DIAGNOSIS_HDR, m_addr[1:0],
				dbank[4*m_addr[1:0] +: 4]};
			2: return {CTRL_HDR, m_addr, m_ctrl[m_addr]};
			default: return {STD_HDR, awake_in, limp_in, pf};
		endcase
	endfunction : answer

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	task automatic do_reset();
		rst = 1'b1;
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		m_err = 1'b1;
		m_kind = 0;
		m_addr = 3'h0;
		foreach (m_ctrl[k])
			m_ctrl[k] = CTRL_RST;
	endtask : do_reset

	// one select window of n clocks; inputs held steady throughout
	task automatic frame(input sra_byte_t b, input int n);
		sra_byte_t   exp_b;
		logic        exp_f;
		logic [31:0] cb;
		int          w;
		int          d0;
		@(negedge core_clk);
		seed = lfsr(seed);
		{dbank, awake_in, limp_in, pf} = seed[21:0];
		exp_b = answer();
		exp_f = m_err | b[7];
		d0 = done_cnt;
		for (w = 0; w < 99 && !req_ready; w++)
			@(negedge core_clk);
		req_valid = 1'b1;
		req_byte = b;
		req_nclk = 5'(n);
		@(negedge core_clk);
		req_valid = 1'b0;
		for (w = 0; w < 999 && !rsp_valid; w++)
			@(negedge core_clk);
		check(rsp_valid, 1'b1);
		check(rsp_flag, exp_f);
		if (n == 8) begin
			check(rsp_byte, exp_b);
			check(wire_byte, b);
			m_err = 1'b0;
			m_ctrl[6] = 4'h0;
			if (b[7]) begin
				// a write ends any pending read; standard word follows
				m_kind = 0;
				if (b[6:4] == CMD_ADDR)
					m_ctrl[6] = {3'h0, b[0]};
				else if (b[6:4] != UNUSED_ADDR)
					m_ctrl[b[6:4]] = b[3:0];
			end else begin
				m_kind = b[STD_BIT] ? 0 : (b[BANK_BIT] ? 1 : 2);
				m_addr = b[6:4];
			end
		end else
			m_err = 1'b1;
		// decode lands a few cycles after the host reports
		repeat (6) @(negedge core_clk);
		for (w = 0; w < 8; w++)
			cb[4*w +: 4] = m_ctrl[w];
		check(err_flag, m_err);
		check(ctrl_bank, cb);
		check(clamp, m_ctrl[6][0]);
		check(done_cnt - d0, 1);
		if (n == 8)
			check(in_matrix, b);
	endtask : frame

	// test sequence
	initial begin
		logic [3:0] v;
		int         n;
		do_reset();
		frame(8'h02, 8);
		frame(8'h02, 8);
		$display("done: standard diagnosis");
		for (n = 0; n < 8; n++) begin
			seed = lfsr(seed);
			v = seed[3:0] | 4'h1;
			frame({1'b1, 3'(n), v}, 8);
			if (n == 6)
				check(last_exec, v);
		end
		$display("done: control writes");
		for (n = 0; n < 9; n++)
			frame({1'b0, 3'(n), seed[1:0], 2'h0}, 8);
		$display("done: control reads");
		for (n = 0; n < 5; n++)
			frame({2'h0, 2'(n), seed[3:2], 2'h1}, 8);
		$display("done: diagnosis reads");
		frame(8'h60, 8);
		frame(8'he1, 8);
		foreach (bad[k])
			frame(seed[7:0], bad[k]);
		frame(8'h02, 8);
		$display("done: bad clock counts");
		do_reset();
		check(err_flag, ERR_FLAG_RST);
		check(ctrl_bank, 32'h0);
		frame(8'h02, 8);
		$display("done: reset in mid-run");
		final_report();
	end

	// cut a hang short at several times the expected run
	initial begin
		repeat (40000) @(posedge core_clk);
		error_cnt++;
		final_report();
	end
endmodule : spi_slave_register_access_tb
`default_nettype wire
